// [inc/mvfr_pkg.sv]
// Purpose: shared constants for the margin and output fault response command slice
// Assumes: 20 MHz core clock; command codes are the host-visible command bytes
// Notes:   nothing here is synthesised on its own
`default_nettype none
package mvfr_pkg;
  // command codes
  localparam logic [7:0]  CMD_MARGIN_HIGH  = 8'h25;
  localparam logic [7:0]  CMD_MARGIN_LOW   = 8'h26;
  localparam logic [7:0]  CMD_CAL_OFFSET   = 8'h39;
  localparam logic [7:0]  CMD_OV_ACTION    = 8'h41;
  localparam logic [7:0]  CMD_UV_ACTION    = 8'h45;
  // reset and fixed values
  localparam logic [7:0]  MARGIN_RST       = 8'h00;
  localparam logic [15:0] CAL_OFFSET_RST   = 16'h0000;
  localparam logic [7:0]  OV_ACTION_VAL    = 8'h80;
  localparam logic [7:0]  UV_ACTION_VAL    = 8'hBA;
  localparam logic [7:0]  UPPER_ZERO       = 8'h00;
  // calibration offset word layout
  localparam int          CAL_EXP_MSB      = 15;
  localparam int          CAL_EXP_LSB      = 11;
  localparam int          CAL_FRAC_MSB     = 10;
  // status bit positions
  localparam int          SB_VOUT_OV_BIT   = 5;
  localparam int          SB_OTHER_BIT     = 0;
  localparam int          SW_VOUT_BIT      = 15;
  localparam int          SV_OV_BIT        = 7;
  localparam int          SV_UV_BIT        = 4;
  // operation mode selection
  localparam logic [1:0]  OPMODE_NOMINAL   = 2'h0;
  localparam logic [1:0]  OPMODE_MARGIN_HI = 2'h1;
  localparam logic [1:0]  OPMODE_MARGIN_LO = 2'h2;
  // restart delay after an undervoltage shutdown
  localparam int          UV_RETRY_MS      = 22;
  localparam int          CLK_KHZ          = 20000;
  localparam int          UV_RETRY_CYCLES  = UV_RETRY_MS * CLK_KHZ;
  // identification code translation: base and step in millivolts per protocol
  localparam logic [11:0] VID_A_BASE_MV    = 12'h0FA;
  localparam logic [11:0] VID_A_STEP_MV    = 12'h005;
  localparam logic [11:0] VID_B_BASE_MV    = 12'h1F4;
  localparam logic [11:0] VID_B_STEP_MV    = 12'h00A;
endpackage : mvfr_pkg
`default_nettype wire

// [inc/mvfr_vid_if.sv]
// Purpose: carries an identification code and its translated voltage
// Assumes: single clock domain, combinational translation
// Notes:   client drives code and protocol, translator answers with millivolts
`timescale 1ns/1ps
`default_nettype none
interface mvfr_vid_if;
  logic [7:0]  code;
  logic        proto_b;
  logic [11:0] mv;
  modport client (output code, output proto_b, input mv);
  modport xlat   (input code, input proto_b, output mv);
endinterface : mvfr_vid_if
`default_nettype wire

// [rtl/mvfr_vid_xlat.sv]
// Purpose: translate a margin identification code into millivolts
// Assumes: code zero means output off; two linear code tables
// Notes:   purely combinational, result is registered by the caller
`timescale 1ns/1ps
`default_nettype none
module mvfr_vid_xlat (
  // code in, voltage out
  mvfr_vid_if.xlat vid
);
  logic [11:0] steps;
  logic [11:0] prod;

  // code 1 is the base voltage, each further code adds one step
  always_comb begin
    steps = {4'h0, vid.code} - 12'h001;
    prod  = vid.proto_b ? 12'(steps * mvfr_pkg::VID_B_STEP_MV)
                        : 12'(steps * mvfr_pkg::VID_A_STEP_MV);
    if (vid.code == 8'h00) begin
      vid.mv = 12'h000;
    end else if (vid.proto_b) begin
      vid.mv = mvfr_pkg::VID_B_BASE_MV + prod;
    end else begin
      vid.mv = mvfr_pkg::VID_A_BASE_MV + prod;
    end
  end
endmodule : mvfr_vid_xlat
`default_nettype wire

// [rtl/mvfr_regs.sv]
// Purpose: margin targets, current read-back offset and output fault responses
// Assumes: command port driven by a same-clock transaction engine
// Notes:   fault comparators and strap arrive asynchronously and are synchronised
//
// Summary of operation
// - Margin-high low byte writable, reset zero, upper byte zero, used in margin high.
// - Margin-low low byte writable, reset zero, upper byte zero, used in margin low.
// - Margin targets travel as two bytes, right-justified identification code.
// - Codes become voltages via table chosen by strap or vendor configuration.
// - Calibration offset corrects output-current read-back; resets to zero.
// - Offset word: signed 5-bit exponent high, signed 11-bit mantissa low.
// - Overvoltage latches off, sets its status bits, asserts alert.
// - After overvoltage shutdown no restart until faults are cleared.
// - Overvoltage response byte is read-only, fixed 80h.
// - Undervoltage sets other, vout word and undervoltage bits, asserts alert.
// - Undervoltage shuts down immediately, then retries after 22 ms.
// - Undervoltage response byte is read-only, fixed BAh.
`timescale 1ns/1ps
`default_nettype none
module mvfr_regs #(
  parameter int RETRY_CYCLES = mvfr_pkg::UV_RETRY_CYCLES
) (
  // clock, reset, enable
  input  wire logic        core_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        ce_in,
  // command port
  input  wire logic [7:0]  cmd_code_in,
  input  wire logic        cmd_wr_in,
  input  wire logic [15:0] cmd_wdata_in,
  input  wire logic        cmd_rd_in,
  output logic      [15:0] cmd_rdata_out,
  output logic             cmd_rvalid_out,
  output logic             cmd_unmapped_out,
  // mode and protocol selection
  input  wire logic [1:0]  op_mode_in,
  input  wire logic        ramp_select_strap_in,
  input  wire logic        vendor_config_thirteen_in,
  input  wire logic        vendor_override_in,
  input  wire logic        clear_faults_in,
  // fault comparators (asynchronous)
  input  wire logic        ov_detect_in,
  input  wire logic        uv_detect_in,
  // current read-back
  input  wire logic [10:0] iout_raw_frac_in,
  output logic      [15:0] iout_corrected_out,
  // converter and status
  output logic             converter_en_out,
  output logic      [7:0]  margin_code_out,
  output logic      [11:0] margin_mv_out,
  output logic      [7:0]  status_byte_out,
  output logic      [15:0] status_word_out,
  output logic      [7:0]  status_vout_out,
  output logic             host_alert_line_out
);
  localparam int CW = $clog2(RETRY_CYCLES + 1);

  typedef enum logic [2:0] {
    MVFR_RUN     = 3'b001,
    MVFR_OV_LOCK = 3'b010,
    MVFR_UV_WAIT = 3'b100
  } mvfr_state_t;

  typedef struct packed {
    logic [1:0]  ov_sync;
    logic [1:0]  uv_sync;
    logic [1:0]  strap_sync;
    mvfr_state_t state;
    logic [CW-1:0] wait_cnt;
    logic [7:0]  margin_high_target;
    logic [7:0]  margin_low_target;
    logic [15:0] current_readback_offset;
    logic [15:0] rdata;
    logic        rvalid;
    logic        unmapped;
    logic [15:0] iout_corr;
    logic        conv_en;
    logic [7:0]  margin_code;
    logic [11:0] margin_mv;
    logic [7:0]  status_byte;
    logic [15:0] status_word;
    logic [7:0]  status_vout;
    logic        alert;
  } mvfr_regs_t;

  // top bit of a margin target inside the two-byte command word
  localparam int TGT_MSB = 7;

  // reset image of the whole state; the converter starts enabled
  localparam mvfr_regs_t S_RST = '{
    ov_sync:                 2'b00,
    uv_sync:                 2'b00,
    strap_sync:              2'b00,
    state:                   MVFR_RUN,
    wait_cnt:                '0,
    margin_high_target:      mvfr_pkg::MARGIN_RST,
    margin_low_target:       mvfr_pkg::MARGIN_RST,
    current_readback_offset: mvfr_pkg::CAL_OFFSET_RST,
    rdata:                   16'h0000,
    rvalid:                  1'b0,
    unmapped:                1'b0,
    iout_corr:               16'h0000,
    conv_en:                 1'b1,
    margin_code:             mvfr_pkg::MARGIN_RST,
    margin_mv:               12'h000,
    status_byte:             8'h00,
    status_word:             16'h0000,
    status_vout:             8'h00,
    alert:                   1'b0
  };

  mvfr_regs_t  s_r;
  mvfr_regs_t  s_nxt;
  mvfr_vid_if  vid ();
  logic        ov_flag;
  logic        uv_flag;
  logic [10:0] frac_sum;
  logic [7:0]  sel_code;
  logic        proto_sel;

  ////////////////////////////////////////////////////////////////////////////
  // translation of the selected margin code
  mvfr_vid_xlat u_xlat (
    .vid (vid.xlat)
  );

  // only the second synchroniser stage is ever read by logic
  assign ov_flag = s_r.ov_sync[1];
  assign uv_flag = s_r.uv_sync[1];

  // vendor configuration wins over the strap once software has chosen
  assign proto_sel = vendor_override_in ? vendor_config_thirteen_in
                                        : s_r.strap_sync[1];

  // nominal mode is served elsewhere, so this slice then offers code zero
  assign sel_code = (op_mode_in == mvfr_pkg::OPMODE_MARGIN_HI) ? s_r.margin_high_target :
                    (op_mode_in == mvfr_pkg::OPMODE_MARGIN_LO) ? s_r.margin_low_target  :
                                                                 mvfr_pkg::MARGIN_RST;

  assign vid.code    = sel_code;
  assign vid.proto_b = proto_sel;

  // limitation: raw reading is assumed to share the offset's exponent
  assign frac_sum = 11'(iout_raw_frac_in +
                        s_r.current_readback_offset[mvfr_pkg::CAL_FRAC_MSB:0]);

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic; everything freezes while the clock enable is low
  always_comb begin
    s_nxt = s_r;
    if (ce_in) begin
      // two-stage synchronisers for pins from outside the clock domain
      s_nxt.ov_sync    = {s_r.ov_sync[0], ov_detect_in};
      s_nxt.uv_sync    = {s_r.uv_sync[0], uv_detect_in};
      s_nxt.strap_sync = {s_r.strap_sync[0], ramp_select_strap_in};
      s_nxt.unmapped   = 1'b0;
      // host writes; response bytes ignore writes rather than flag them
      if (cmd_wr_in) begin
        case (cmd_code_in)
          mvfr_pkg::CMD_MARGIN_HIGH: begin
            s_nxt.margin_high_target = cmd_wdata_in[TGT_MSB:0];
          end
          mvfr_pkg::CMD_MARGIN_LOW: begin
            s_nxt.margin_low_target = cmd_wdata_in[TGT_MSB:0];
          end
          mvfr_pkg::CMD_CAL_OFFSET: begin
            s_nxt.current_readback_offset = cmd_wdata_in;
          end
          mvfr_pkg::CMD_OV_ACTION, mvfr_pkg::CMD_UV_ACTION: begin
            s_nxt.unmapped = 1'b0;
          end
          default: begin
            s_nxt.unmapped = 1'b1;
          end
        endcase
      end
      // host reads answer one cycle later; targets come back right-justified
      s_nxt.rvalid = cmd_rd_in;
      if (cmd_rd_in) begin
        case (cmd_code_in)
          mvfr_pkg::CMD_MARGIN_HIGH: begin
            s_nxt.rdata = {mvfr_pkg::UPPER_ZERO, s_r.margin_high_target};
          end
          mvfr_pkg::CMD_MARGIN_LOW: begin
            s_nxt.rdata = {mvfr_pkg::UPPER_ZERO, s_r.margin_low_target};
          end
          mvfr_pkg::CMD_CAL_OFFSET: begin
            s_nxt.rdata = s_r.current_readback_offset;
          end
          mvfr_pkg::CMD_OV_ACTION: begin
            s_nxt.rdata = {mvfr_pkg::UPPER_ZERO, mvfr_pkg::OV_ACTION_VAL};
          end
          mvfr_pkg::CMD_UV_ACTION: begin
            s_nxt.rdata = {mvfr_pkg::UPPER_ZERO, mvfr_pkg::UV_ACTION_VAL};
          end
          default: begin
            s_nxt.rdata    = 16'h0000;
            s_nxt.unmapped = 1'b1;
          end
        endcase
      end
      // clear first, then set, so a fault in the clearing cycle survives
      if (clear_faults_in) begin
        s_nxt.status_byte = 8'h00;
        s_nxt.status_vout = 8'h00;
      end
      if (ov_flag) begin
        s_nxt.status_byte[mvfr_pkg::SB_VOUT_OV_BIT] = 1'b1;
        s_nxt.status_vout[mvfr_pkg::SV_OV_BIT]      = 1'b1;
      end
      if (uv_flag) begin
        s_nxt.status_byte[mvfr_pkg::SB_OTHER_BIT] = 1'b1;
        s_nxt.status_vout[mvfr_pkg::SV_UV_BIT]    = 1'b1;
      end
      // converter control: overvoltage wins over a pending undervoltage retry
      case (s_r.state)
        MVFR_RUN: begin
          if (ov_flag) begin
            s_nxt.state   = MVFR_OV_LOCK;
            s_nxt.conv_en = 1'b0;
          end else if (uv_flag) begin
            s_nxt.state    = MVFR_UV_WAIT;
            s_nxt.conv_en  = 1'b0;
            s_nxt.wait_cnt = CW'(RETRY_CYCLES - 1);
          end
        end
        MVFR_OV_LOCK: begin
          // no retry: only a host clear lets the output come back
          if (clear_faults_in) begin
            s_nxt.state   = MVFR_RUN;
            s_nxt.conv_en = 1'b1;
          end else begin
            s_nxt.conv_en = 1'b0;
          end
        end
        MVFR_UV_WAIT: begin
          if (ov_flag) begin
            s_nxt.state   = MVFR_OV_LOCK;
            s_nxt.conv_en = 1'b0;
          end else if (s_r.wait_cnt == '0) begin
            s_nxt.state   = MVFR_RUN;
            s_nxt.conv_en = 1'b1;
          end else begin
            s_nxt.wait_cnt = s_r.wait_cnt - CW'(1);
          end
        end
        default: begin
          s_nxt.state   = MVFR_RUN;
          s_nxt.conv_en = 1'b0;
        end
      endcase
      s_nxt.status_word                       = 16'h0000;
      s_nxt.status_word[mvfr_pkg::SW_VOUT_BIT] = |s_nxt.status_vout;
      s_nxt.alert = (|s_nxt.status_byte) | (|s_nxt.status_vout);
      // registered margin code and its translated voltage
      s_nxt.margin_code = sel_code;
      s_nxt.margin_mv   = vid.mv;
      s_nxt.iout_corr   = {s_r.current_readback_offset[mvfr_pkg::CAL_EXP_MSB:
                                                       mvfr_pkg::CAL_EXP_LSB],
                           frac_sum};
    end
  end

  // state register
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_r <= S_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs come straight from the state register
  assign cmd_rdata_out       = s_r.rdata;
  assign cmd_rvalid_out      = s_r.rvalid;
  assign cmd_unmapped_out    = s_r.unmapped;
  assign iout_corrected_out  = s_r.iout_corr;
  assign converter_en_out    = s_r.conv_en;
  assign margin_code_out     = s_r.margin_code;
  assign margin_mv_out       = s_r.margin_mv;
  assign status_byte_out     = s_r.status_byte;
  assign status_word_out     = s_r.status_word;
  assign status_vout_out     = s_r.status_vout;
  assign host_alert_line_out = s_r.alert;

  ////////////////////////////////////////////////////////////////////////////
  // checks on the fault responses and the fixed command bytes
  default clocking cb_core @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence seq_ov_entry;
    ce_in && (s_r.state != MVFR_OV_LOCK) && ov_flag;
  endsequence

  sequence seq_uv_entry;
    ce_in && (s_r.state == MVFR_RUN) && uv_flag && !ov_flag;
  endsequence

  sequence seq_uv_expire;
    ce_in && (s_r.state == MVFR_UV_WAIT) && (s_r.wait_cnt == '0) && !ov_flag;
  endsequence

  AST_OV_RESPONSE: assert property (
    seq_ov_entry |=> !converter_en_out && status_byte_out[mvfr_pkg::SB_VOUT_OV_BIT] &&
      status_vout_out[mvfr_pkg::SV_OV_BIT] && status_word_out[mvfr_pkg::SW_VOUT_BIT] &&
      host_alert_line_out)
    else $error("overvoltage response incomplete");

  AST_OV_STAYS_OFF: assert property (
    ce_in && (s_r.state == MVFR_OV_LOCK) && !clear_faults_in |=> !converter_en_out)
    else $error("converter restarted after overvoltage without a clear");

  AST_UV_RESPONSE: assert property (
    seq_uv_entry |=> !converter_en_out && status_byte_out[mvfr_pkg::SB_OTHER_BIT] &&
      status_vout_out[mvfr_pkg::SV_UV_BIT] && status_word_out[mvfr_pkg::SW_VOUT_BIT] &&
      host_alert_line_out)
    else $error("undervoltage response incomplete");

  AST_UV_HOLD_OFF: assert property (
    ce_in && (s_r.state == MVFR_UV_WAIT) && (s_r.wait_cnt != '0) |=> !converter_en_out)
    else $error("converter restarted before the retry delay ran out");

  AST_UV_RETRY: assert property (
    seq_uv_expire |=> converter_en_out)
    else $error("no restart when the retry delay ran out");

  AST_OV_ACTION_FIXED: assert property (
    ce_in && cmd_rd_in && (cmd_code_in == mvfr_pkg::CMD_OV_ACTION) |=>
      cmd_rvalid_out && (cmd_rdata_out == {mvfr_pkg::UPPER_ZERO, mvfr_pkg::OV_ACTION_VAL}))
    else $error("overvoltage response byte read wrong");

  AST_UV_ACTION_FIXED: assert property (
    ce_in && cmd_rd_in && (cmd_code_in == mvfr_pkg::CMD_UV_ACTION) |=>
      cmd_rvalid_out && (cmd_rdata_out == {mvfr_pkg::UPPER_ZERO, mvfr_pkg::UV_ACTION_VAL}))
    else $error("undervoltage response byte read wrong");

  AST_MARGIN_HIGH_UPPER: assert property (
    ce_in && cmd_rd_in && (cmd_code_in == mvfr_pkg::CMD_MARGIN_HIGH) |=>
      (cmd_rdata_out[15:8] == mvfr_pkg::UPPER_ZERO))
    else $error("margin high upper byte not zero");

  AST_MARGIN_LOW_UPPER: assert property (
    ce_in && cmd_rd_in && (cmd_code_in == mvfr_pkg::CMD_MARGIN_LOW) |=>
      (cmd_rdata_out[15:8] == mvfr_pkg::UPPER_ZERO))
    else $error("margin low upper byte not zero");

  AST_FLAGS_HOLD: assert property (
    !clear_faults_in |=> ((status_byte_out & $past(status_byte_out)) == $past(status_byte_out)))
    else $error("status flag dropped without a clear");

  AST_ALERT_MATCH: assert property (
    host_alert_line_out == ((|status_byte_out) || (|status_vout_out)))
    else $error("alert line disagrees with the status flags");
endmodule : mvfr_regs
`default_nettype wire

// [verification/mvfr_host_model.sv]
// Purpose: host model issuing command writes and reads
// Assumes: requests change 1 ns after the rising edge
// Notes:   a read waits at most 16 cycles for its answer
`timescale 1ns/1ps
`default_nettype none
module mvfr_host_model (
  // clock
  input  wire logic        clk_in,
  // command side
  output logic      [7:0]  code_out,
  output logic             wr_out,
  output logic      [15:0] wdata_out,
  output logic             rd_out,
  input  wire logic [15:0] rdata_in,
  input  wire logic        rvalid_in
);
  initial {code_out, wr_out, wdata_out, rd_out} = '0;
  // one-cycle write strobe; target words go as two right-justified bytes
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    code_out = c;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1 wr_out = 1'b0;
    // one idle edge so a following request never re-raises the strobe at once
    @(posedge clk_in);
    #1;
  endtask : wr
  // read held until the answer is seen at a rising edge, bounded wait
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output bit ok);
    ok = 1'b0;
    d = 16'h0000;
    code_out = c;
    rd_out = 1'b1;
    // the answer is taken at the rising edge where it is seen valid
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge clk_in);
      ok = (rvalid_in === 1'b1);
      if (ok) d = rdata_in;
    end
    #1 rd_out = 1'b0;
    // idle edge flushes the stale answer before the next request
    @(posedge clk_in);
    #1;
  endtask : rd
endmodule : mvfr_host_model
`default_nettype wire

// [verification/test_margin_and_vout_fault_response_regs.sv]
// Purpose: self-checking bench for margin targets and fault responses
// Assumes: short retry delay parameter so the restart is seen quickly
// Notes:   strap and vendor selection inputs are tied low
`timescale 1ns/1ps
`default_nettype none
module test_margin_and_vout_fault_response_regs;
  localparam int RC = 20;
  logic clk = 0, rst_b = 0, ov = 0, uv = 0, clr = 0, wr, rd, rv, en, al;
  logic [7:0] code, sb, sv, mc;
  logic [15:0] wd, rdat, sw, io;
  logic [11:0] mv;
  logic [1:0] om = 2'h0;
  int num_errors = 0, samples_checked = 0;
  initial forever #25 clk = ~clk;
  mvfr_host_model HOST (.clk_in(clk), .code_out(code), .wr_out(wr), .wdata_out(wd),
    .rd_out(rd), .rdata_in(rdat), .rvalid_in(rv));
  mvfr_regs #(.RETRY_CYCLES(RC)) DUT (.core_clk_in(clk), .rst_b_in(rst_b), .ce_in(1'b1),
    .cmd_code_in(code), .cmd_wr_in(wr), .cmd_wdata_in(wd), .cmd_rd_in(rd),
    .cmd_rdata_out(rdat), .cmd_rvalid_out(rv), .cmd_unmapped_out(), .op_mode_in(om),
    .ramp_select_strap_in(1'b0), .vendor_config_thirteen_in(1'b0),
    .vendor_override_in(1'b0), .clear_faults_in(clr), .ov_detect_in(ov),
    .uv_detect_in(uv), .iout_raw_frac_in(11'h000), .iout_corrected_out(io),
    .converter_en_out(en), .margin_code_out(mc), .margin_mv_out(mv), .status_byte_out(sb),
    .status_word_out(sw), .status_vout_out(sv), .host_alert_line_out(al));
  task automatic wrap_up;
    if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  // a read that never answers ends the run
  task automatic rchk(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] d;
    bit ok;
    HOST.rd(c, d, ok);
    if (!ok) begin
      num_errors++;
      wrap_up();
    end
    chk(e, d);
  endtask : rchk
  task automatic t_regs;
    rchk(8'h25, 16'h0000);
    rchk(8'h26, 16'h0000);
    rchk(8'h39, 16'h0000);
    HOST.wr(8'h25, 16'hFF5A);
    HOST.wr(8'h26, 16'hA5C3);
    HOST.wr(8'h39, 16'hF801);
    HOST.wr(8'h41, 16'h0011);
    HOST.wr(8'h45, 16'h0022);
    rchk(8'h25, 16'h005A);
    rchk(8'h26, 16'h00C3);
    rchk(8'h39, 16'hF801);
    rchk(8'h41, 16'h0080);
    rchk(8'h45, 16'h00BA);
  endtask : t_regs
  // margin modes select the stored codes; table A is 250 mV plus 5 mV steps
  task automatic t_margin;
    om = 2'h1;
    repeat (2) @(posedge clk);
    chk(16'h005A, {8'h0, mc});
    chk(16'h02B7, {4'h0, mv});
    #1 om = 2'h2;
    repeat (2) @(posedge clk);
    chk(16'h00C3, {8'h0, mc});
    chk(16'h04C4, {4'h0, mv});
    chk(16'hF801, io);
    #1 om = 2'h0;
  endtask : t_margin
  // fault input held, then released, then cleared by the host
  task automatic t_fault(input bit is_ov);
    if (is_ov) ov = 1;
    else uv = 1;
    repeat (6) @(posedge clk);
    chk(is_ov ? 16'h0020 : 16'h0001, {8'h0, sb});
    chk(is_ov ? 16'h001A : 16'h0016, {sw[15], sv[7], sv[4], al, en});
    #1 {ov, uv} = 0;
    repeat (RC + 10) @(posedge clk);
    chk(is_ov ? 16'h0002 : 16'h0003, {al, en});
    #1 clr = 1;
    @(posedge clk);
    #1 clr = 0;
    repeat (4) @(posedge clk);
    chk(16'h0001, {sb, al, en});
  endtask : t_fault
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_b = 1;
    t_regs();
    t_margin();
    t_fault(1'b0);
    t_fault(1'b1);
    wrap_up();
  end
endmodule : test_margin_and_vout_fault_response_regs
`default_nettype wire
